// ===== design/csr_map.vh
`ifndef CSR_MAP_VH
`define CSR_MAP_VH
// Register offsets on the management port
`define CSR_ADDR_CHG_REG_STAT 8'h0b
`define CSR_ADDR_SRC_STAT 8'h0c
`define CSR_ADDR_THERM_STAT 8'h0d
`define CSR_ADDR_FAULT_STAT 8'h0e
`define CSR_ADDR_EVENT 8'h0f
// Field positions
`define CSR_BIT_ADC_DONE 7
`define CSR_BIT_CUR_LIM 6
`define CSR_BIT_VLIM 5
`define CSR_BIT_TREG 4
`define CSR_BIT_WDOG 3
`define CSR_BIT_PGOOD 7
`define CSR_BIT_MINSYS 0
`define CSR_BIT_OVP 7
`define CSR_BIT_TSHUT 6
`define CSR_BIT_BATOVP 5
`define CSR_BIT_TMR 4
`define CSR_BIT_PHASE_EVT 0
// Codes
`define CSR_PHASE_RESERVED 3'h7
`define CSR_ICO_RESERVED 2'h3
`define CSR_ZONE_NORMAL 3'h0
`define CSR_ZONE_WARM 3'h2
`define CSR_ZONE_COOL 3'h3
`define CSR_ZONE_COLD 3'h5
`define CSR_ZONE_HOT 3'h6
`define CSR_RESET_BYTE 8'h00
`endif

// ===== design/csr_status_regs.v
// Contract
// - Bit7 status1 shows single-shot conversion done; always 0 in continuous mode.
// - Bit6 status1 shows input current limit loop active, pin or register.
// - Bit5 status1 shows input voltage limit loop regulating.
// - Bit4 status1 shows die thermal regulation loop active.
// - Bit3 status1 shows host timeout timer expired.
// - Bits2:0 status1 phase codes idle, trickle, pre-charge, fast charge.
// - Phase codes taper, top-off, done; code 111 never reported.
// - Source codes weak, unknown, non-standard, OTG output mode.
// - Status2 bits2:1 optimizer disabled, searching, found; 11 reserved.
// - Status2 bit0 shows minimum system regulation active.
// - Thermistor zone codes normal, warm, cool, cold, hot; upper bits zero.
// - Fault bit7 shows input overvoltage protection active.
// - Fault bit6 shows thermal shutdown.
// - Fault bit5 shows battery above overvoltage threshold.
// - Fault bit4 shows safety timer expired.
// - All reserved bits read zero.
// - Any change between legal charge phase codes sets a sticky readable event flag.
`include "csr_map.vh"

module csr_status_regs (
  input wire clk,
  input wire reset,
  input wire adc_one_shot_done,
  input wire adc_continuous,
  input wire input_current_limit_active,
  input wire input_voltage_limit_active,
  input wire die_thermal_loop_active,
  input wire host_timeout_expired,
  input wire [2:0] charge_phase,
  input wire power_good_status,
  input wire [2:0] input_source_type,
  input wire [1:0] input_optimizer_state,
  input wire min_system_regulation_active,
  input wire [2:0] thermistor_zone,
  input wire input_overvoltage_status,
  input wire thermal_shutdown_status,
  input wire battery_overvoltage_status,
  input wire safety_timer_expired,
  input wire soft_reg_reset,
  input wire rd_en,
  input wire wr_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  output reg charge_phase_change_event
);

  ////////////////////////////////////////////////////////////////
  // Two-stage synchronisers: the analog conditions are asynchronous
  localparam NB = 26;
  wire [NB-1:0] raw_in;
  reg [NB-1:0] meta_q;
  reg [NB-1:0] sync_q;

  assign raw_in = {
    adc_one_shot_done,
    adc_continuous,
    input_current_limit_active,
    input_voltage_limit_active,
    die_thermal_loop_active,
    host_timeout_expired,
    charge_phase,
    power_good_status,
    input_source_type,
    input_optimizer_state,
    min_system_regulation_active,
    thermistor_zone,
    input_overvoltage_status,
    thermal_shutdown_status,
    battery_overvoltage_status,
    safety_timer_expired,
    soft_reg_reset,
    rd_en,
    wr_en
  };

  always @(posedge clk) begin
    if (reset) begin
      meta_q <= {NB{1'b0}};
      sync_q <= {NB{1'b0}};
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  wire s_adc_done = sync_q[25];
  wire s_adc_cont = sync_q[24];
  wire s_cur_lim = sync_q[23];
  wire s_vlim = sync_q[22];
  wire s_treg = sync_q[21];
  wire s_wdog = sync_q[20];
  wire [2:0] s_phase = sync_q[19:17];
  wire s_pgood = sync_q[16];
  wire [2:0] s_src = sync_q[15:13];
  wire [1:0] s_ico = sync_q[12:11];
  wire s_minsys = sync_q[10];
  wire [2:0] s_zone = sync_q[9:7];
  wire s_ovp = sync_q[6];
  wire s_tshut = sync_q[5];
  wire s_batovp = sync_q[4];
  wire s_tmr = sync_q[3];
  wire s_soft_rst = sync_q[2];
  wire s_rd = sync_q[1];

  ////////////////////////////////////////////////////////////////
  // Address passes the same two stages as the read strobe,
  // so both reach the decode on the same edge
  reg [7:0] addr_meta_q;
  reg [7:0] addr_sync_q;

  always @(posedge clk) begin
    if (reset) begin
      addr_meta_q <= 8'h00;
      addr_sync_q <= 8'h00;
    end else begin
      addr_meta_q <= addr;
      addr_sync_q <= addr_meta_q;
    end
  end

  wire [7:0] s_addr = addr_sync_q;

  ////////////////////////////////////////////////////////////////
  // Live status bytes
  reg [7:0] chg_reg_stat_q;
  reg [7:0] chg_reg_stat_d;
  reg [7:0] src_stat_q;
  reg [7:0] src_stat_d;
  reg [7:0] therm_stat_q;
  reg [7:0] therm_stat_d;
  reg [7:0] fault_stat_q;
  reg [7:0] fault_stat_d;
  reg [2:0] phase_q;
  reg [2:0] phase_d;
  reg [2:0] src_d;
  reg [1:0] ico_q;
  reg [1:0] ico_d;
  reg [2:0] zone_d;
  reg adc_done_d;

  ////////////////////////////////////////////////////////////////
  // Charge phase: legal codes pass, the reserved code keeps the
  // last legal phase so a pass through it is never shown
  always @* begin
    case (s_phase)
      3'h0: phase_d = 3'h0;
      3'h1: phase_d = 3'h1;
      3'h2: phase_d = 3'h2;
      3'h3: phase_d = 3'h3;
      3'h4: phase_d = 3'h4;
      3'h5: phase_d = 3'h5;
      3'h6: phase_d = 3'h6;
      default: phase_d = phase_q;
    endcase
  end

  // Continuous conversions never report done
  always @* begin
    if (s_adc_cont) begin
      adc_done_d = 1'b0;
    end else begin
      adc_done_d = s_adc_done;
    end
  end

  always @* begin
    chg_reg_stat_d = `CSR_RESET_BYTE;
    chg_reg_stat_d[`CSR_BIT_ADC_DONE] = adc_done_d;
    chg_reg_stat_d[`CSR_BIT_CUR_LIM] = s_cur_lim;
    chg_reg_stat_d[`CSR_BIT_VLIM] = s_vlim;
    chg_reg_stat_d[`CSR_BIT_TREG] = s_treg;
    chg_reg_stat_d[`CSR_BIT_WDOG] = s_wdog;
    chg_reg_stat_d[2:0] = phase_d;
  end

  ////////////////////////////////////////////////////////////////
  // Input source: all eight codes are legal and pass unchanged
  always @* begin
    case (s_src)
      3'h0: src_d = 3'h0;
      3'h1: src_d = 3'h1;
      3'h2: src_d = 3'h2;
      3'h3: src_d = 3'h3;
      3'h4: src_d = 3'h4;
      3'h5: src_d = 3'h5;
      3'h6: src_d = 3'h6;
      default: src_d = 3'h7;
    endcase
  end

  // The reserved optimizer code keeps the last reported state
  always @* begin
    case (s_ico)
      2'h0: ico_d = 2'h0;
      2'h1: ico_d = 2'h1;
      2'h2: ico_d = 2'h2;
      default: ico_d = ico_q;
    endcase
  end

  always @* begin
    src_stat_d = `CSR_RESET_BYTE;
    src_stat_d[`CSR_BIT_PGOOD] = s_pgood;
    src_stat_d[6:4] = src_d;
    src_stat_d[2:1] = ico_d;
    src_stat_d[`CSR_BIT_MINSYS] = s_minsys;
  end

  ////////////////////////////////////////////////////////////////
  // Thermistor zone: codes without a zone read as normal
  always @* begin
    case (s_zone)
      `CSR_ZONE_WARM: zone_d = `CSR_ZONE_WARM;
      `CSR_ZONE_COOL: zone_d = `CSR_ZONE_COOL;
      `CSR_ZONE_COLD: zone_d = `CSR_ZONE_COLD;
      `CSR_ZONE_HOT: zone_d = `CSR_ZONE_HOT;
      default: zone_d = `CSR_ZONE_NORMAL;
    endcase
  end

  always @* begin
    therm_stat_d = {5'h00, zone_d};
  end

  ////////////////////////////////////////////////////////////////
  // Fault byte; the low nibble is reserved
  always @* begin
    fault_stat_d = `CSR_RESET_BYTE;
    fault_stat_d[`CSR_BIT_OVP] = s_ovp;
    fault_stat_d[`CSR_BIT_TSHUT] = s_tshut;
    fault_stat_d[`CSR_BIT_BATOVP] = s_batovp;
    fault_stat_d[`CSR_BIT_TMR] = s_tmr;
  end

  ////////////////////////////////////////////////////////////////
  // Only the power-on reset clears these; soft reset and writes are ignored
  always @(posedge clk) begin
    if (reset) begin
      chg_reg_stat_q <= `CSR_RESET_BYTE;
      src_stat_q <= `CSR_RESET_BYTE;
      therm_stat_q <= `CSR_RESET_BYTE;
      fault_stat_q <= `CSR_RESET_BYTE;
      phase_q <= 3'h0;
      ico_q <= 2'h0;
    end else begin
      chg_reg_stat_q <= chg_reg_stat_d;
      src_stat_q <= src_stat_d;
      therm_stat_q <= therm_stat_d;
      fault_stat_q <= fault_stat_d;
      phase_q <= phase_d;
      ico_q <= ico_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sticky phase-change event, cleared by reading the event byte
  reg rd_d1_q;
  reg evt_d;
  reg [7:0] rd_mux_d;
  wire rd_pulse = s_rd & ~rd_d1_q;
  // Compared before the phase register moves, so every legal step counts
  wire phase_changed = phase_d != phase_q;
  wire evt_read = rd_pulse && (s_addr == `CSR_ADDR_EVENT);

  // Set beats clear so a change during the read is not lost
  always @* begin
    if (phase_changed) begin
      evt_d = 1'b1;
    end else if (evt_read || s_soft_rst) begin
      evt_d = 1'b0;
    end else begin
      evt_d = charge_phase_change_event;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      rd_d1_q <= 1'b0;
      charge_phase_change_event <= 1'b0;
    end else begin
      rd_d1_q <= s_rd;
      charge_phase_change_event <= evt_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read port; writes never reach the status bytes
  always @* begin
    case (s_addr)
      `CSR_ADDR_CHG_REG_STAT: rd_mux_d = chg_reg_stat_q;
      `CSR_ADDR_SRC_STAT: rd_mux_d = src_stat_q;
      `CSR_ADDR_THERM_STAT: rd_mux_d = therm_stat_q;
      `CSR_ADDR_FAULT_STAT: rd_mux_d = fault_stat_q;
      `CSR_ADDR_EVENT: rd_mux_d = {7'h00, charge_phase_change_event};
      default: rd_mux_d = `CSR_RESET_BYTE;
    endcase
  end

  // Data holds between reads so a slow host may sample late
  always @(posedge clk) begin
    if (reset) begin
      rdata <= `CSR_RESET_BYTE;
    end else if (rd_pulse) begin
      rdata <= rd_mux_d;
    end
  end

endmodule // csr_status_regs

// ===== verification/csr_host.sv
module csr_host (
  input wire clk,
  input wire [7:0] rdata,
  output reg rd_en = 1'b0,
  output reg wr_en = 1'b0,
  output reg [7:0] addr = 8'h00,
  output reg [7:0] wdata = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // Long strobe and gap so the block's synchroniser never merges two accesses
  task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    rd_en = ~w;
    wr_en = w;
    repeat (8) @(posedge clk);
    q = rdata;
    #1;
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
    repeat (7) @(posedge clk);
    #1;
  endtask
endmodule // csr_host

// ===== verification/csr_status_regs_chk.sv
module csr_chk (
  input wire clk,
  input wire reset,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [2:0] charge_phase,
  input wire [7:0] rdata,
  input wire charge_phase_change_event
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] hi_q;
  // Read data is judged only once the strobe has outlasted the sync delay
  wire done = rd_en && hi_q > 4'h5;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  always @(posedge clk) begin
    if (reset || !rd_en) hi_q <= 4'h0;
    else if (hi_q != 4'hf) hi_q <= hi_q + 4'h1;
  end
  AST_HOLD: assert property ($changed(rdata) |-> $past(rd_en, 3) || $past(rd_en, 5))
    else $error("rdata moved");
  AST_THERM: assert property (done && addr == 8'h0d |-> rdata[7:3] == 5'h00)
    else $error("zone upper bits");
  AST_FLT_LO: assert property (done && addr == 8'h0e |-> rdata[3:0] == 4'h0)
    else $error("fault low bits");
  AST_SRC_B3: assert property (done && addr == 8'h0c |-> !rdata[3])
    else $error("source bit3");
  AST_ICO: assert property (done && addr == 8'h0c |-> rdata[2:1] != 2'h3)
    else $error("optimizer code");
  AST_PHASE: assert property (done && addr == 8'h0b && charge_phase != 3'h7 |-> rdata[2:0] == charge_phase)
    else $error("phase field");
  AST_NO7: assert property (done && addr == 8'h0b |-> rdata[2:0] != 3'h7)
    else $error("phase 7 shown");
  AST_EVT: assert property ($changed(charge_phase) && charge_phase != 3'h7 && $past(charge_phase) != 3'h7
    |-> ##[3:6] charge_phase_change_event) else $error("no phase event");
endmodule // csr_chk
bind csr_status_regs csr_chk u_chk (.clk(clk), .reset(reset), .rd_en(rd_en), .addr(addr),
  .charge_phase(charge_phase), .rdata(rdata), .charge_phase_change_event(charge_phase_change_event));

// ===== verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg srr = 1'b0;
  reg [5:0] s1 = 6'h00;
  reg [2:0] ph = 3'h0;
  reg [6:0] s2 = 7'h00;
  reg [2:0] zn = 3'h0;
  reg [3:0] ft = 4'h0;
  reg [4:0] i;
  reg [7:0] q;
  wire rd_en, wr_en, ev;
  wire [7:0] addr, wdata, rdata;
  integer miscompares = 0;
  integer n_tests = 0;
  always #12.5 clk = ~clk;
  csr_host host (.clk(clk), .rdata(rdata), .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wdata(wdata));
  csr_status_regs DUT (.clk(clk), .reset(reset), .adc_one_shot_done(s1[5]), .adc_continuous(s1[4]),
    .input_current_limit_active(s1[3]), .input_voltage_limit_active(s1[2]), .die_thermal_loop_active(s1[1]),
    .host_timeout_expired(s1[0]), .charge_phase(ph), .power_good_status(s2[6]), .input_source_type(s2[5:3]),
    .input_optimizer_state(s2[2:1]), .min_system_regulation_active(s2[0]), .thermistor_zone(zn),
    .input_overvoltage_status(ft[3]), .thermal_shutdown_status(ft[2]), .battery_overvoltage_status(ft[1]),
    .safety_timer_expired(ft[0]), .soft_reg_reset(srr), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .charge_phase_change_event(ev));
  //////////////////////////////
  task chk(input [7:0] seen, input [7:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    host.xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task end_sim;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    #60000;
    miscompares = miscompares + 1;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      s1 = {1'b1, i[1], i[3:0] ^ 4'h5};
      ph = i[2:0];
      rd(8'h0b, {~i[1], i[3:0] ^ 4'h5, i == 5'd7 ? 3'h6 : i[2:0]});
    end
    chk({7'h00, ev}, 8'h01);
    rd(8'h0f, 8'h01);
    chk({7'h00, ev}, 8'h00);
    rd(8'h0f, 8'h00);
    $display("status one test done");
    for (i = 0; i < 8; i = i + 1) begin
      s2 = {~i[0], i[2:0], i[2:1], i[1]};
      rd(8'h0c, {~i[0], i[2:0], 1'b0, i[2:1] == 2'h3 ? 2'h2 : i[2:1], i[1]});
    end
    for (i = 0; i < 5; i = i + 1) begin
      zn = i[2:0] + ((i[2:0] + 3'h1) >> 1);
      rd(8'h0d, {5'h00, zn});
    end
    zn = 3'h7;
    rd(8'h0d, 8'h00);
    for (i = 0; i < 16; i = i + 1) begin
      ft = i[3:0];
      rd(8'h0e, {i[3:0], 4'h0});
    end
    $display("status two to fault test done");
    host.xfer(1'b1, 8'h0b, 8'hff, q);
    ph = 3'h2;
    repeat (8) @(posedge clk);
    #1;
    chk({7'h00, ev}, 8'h01);
    srr = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srr = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({7'h00, ev}, 8'h00);
    rd(8'h0f, 8'h00);
    rd(8'h0b, 8'h12);
    rd(8'h3c, 8'h00);
    $display("write and soft reset test done");
    end_sim;
  end
endmodule // tb_top
